// [amode_pkg.sv]
package amode_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Prebyte codes and special opcodes
   localparam logic [7:0] PRE_Y_CODE = 8'h90;
   localparam logic [7:0] PRE_IND_Y_CODE = 8'h91;
   localparam logic [7:0] PRE_IND_CODE = 8'h92;
   localparam logic [7:0] OPC_HALT = 8'h8e;
   localparam logic [7:0] OPC_WFI = 8'h8f;
   // Undefined codes inside inherent rows 8 and 9, one bit per low nibble
   // Codes 8a, 8b and 93 only; 8e is the halt opcode and must stay legal
   localparam logic [15:0] ILL_ROW8 = 16'h0c00;
   localparam logic [15:0] ILL_ROW9 = 16'h0008;
   localparam logic [7:0] PAGE0_HI = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam int N_MODES = 17;
   localparam int N_FAMILIES = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcode rows, selected by the high nibble
   localparam logic [3:0] NIB_BIT_REL = 4'h0;
   localparam logic [3:0] NIB_BIT = 4'h1;
   localparam logic [3:0] NIB_JR = 4'h2;
   localparam logic [3:0] NIB_RMW_DIR = 4'h3;
   localparam logic [3:0] NIB_INH_A = 4'h4;
   localparam logic [3:0] NIB_INH_X = 4'h5;
   localparam logic [3:0] NIB_RMW_IDX = 4'h6;
   localparam logic [3:0] NIB_RMW_IDX0 = 4'h7;
   localparam logic [3:0] NIB_INH_8 = 4'h8;
   localparam logic [3:0] NIB_INH_9 = 4'h9;
   localparam logic [3:0] NIB_IMM = 4'ha;
   localparam logic [3:0] NIB_DIR_S = 4'hb;
   localparam logic [3:0] NIB_DIR_L = 4'hc;
   localparam logic [3:0] NIB_IDX_L = 4'hd;
   localparam logic [3:0] NIB_IDX_S = 4'he;
   localparam logic [3:0] NIB_IDX_0 = 4'hf;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [4:0] {
      AM_INHERENT = 5'h00, AM_IMMEDIATE = 5'h01, AM_DIR_SHORT = 5'h02,
      AM_DIR_LONG = 5'h03, AM_IDX_NONE = 5'h04, AM_IDX_SHORT = 5'h05,
      AM_IDX_LONG = 5'h06, AM_IND_SHORT = 5'h07, AM_IND_LONG = 5'h08,
      AM_IND_IDX_SHORT = 5'h09, AM_IND_IDX_LONG = 5'h0a, AM_REL_DIR = 5'h0b,
      AM_REL_IND = 5'h0c, AM_BIT_DIR = 5'h0d, AM_BIT_IND = 5'h0e,
      AM_BIT_DIR_REL = 5'h0f, AM_BIT_IND_REL = 5'h10
   } amode_t;

   typedef enum logic [2:0] {
      FAM_INHERENT = 3'h0, FAM_IMMEDIATE = 3'h1, FAM_DIRECT = 3'h2, FAM_INDEXED = 3'h3,
      FAM_INDIRECT = 3'h4, FAM_RELATIVE = 3'h5, FAM_BIT = 3'h6
   } family_t;

   typedef enum logic [1:0] {
      PRE_NONE = 2'b00, PRE_SEL_Y = 2'b01, PRE_SEL_IND = 2'b10, PRE_SEL_IND_Y = 2'b11
   } pre_t;

   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000, ST_OPERAND = 3'b001, ST_PTR_HI = 3'b010,
      ST_PTR_LO = 3'b011, ST_FINISH = 3'b100
   } state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Shared decoding
   function automatic pre_t pre_code(input logic [7:0] b);
      case (b)
         PRE_Y_CODE: pre_code = PRE_SEL_Y;
         PRE_IND_CODE: pre_code = PRE_SEL_IND;
         PRE_IND_Y_CODE: pre_code = PRE_SEL_IND_Y;
         default: pre_code = PRE_NONE;
      endcase
   endfunction

   function automatic family_t family_of(input amode_t m);
      case (m)
         AM_INHERENT: family_of = FAM_INHERENT;
         AM_IMMEDIATE: family_of = FAM_IMMEDIATE;
         AM_DIR_SHORT, AM_DIR_LONG: family_of = FAM_DIRECT;
         AM_IDX_NONE, AM_IDX_SHORT, AM_IDX_LONG: family_of = FAM_INDEXED;
         AM_REL_DIR, AM_REL_IND: family_of = FAM_RELATIVE;
         AM_BIT_DIR, AM_BIT_IND, AM_BIT_DIR_REL, AM_BIT_IND_REL: family_of = FAM_BIT;
         default: family_of = FAM_INDIRECT;
      endcase
   endfunction

   function automatic logic is_indirect(input amode_t m);
      is_indirect = (m == AM_IND_SHORT) || (m == AM_IND_LONG) || (m == AM_IND_IDX_SHORT)
         || (m == AM_IND_IDX_LONG) || (m == AM_REL_IND) || (m == AM_BIT_IND)
         || (m == AM_BIT_IND_REL);
   endfunction

   function automatic logic is_branch(input amode_t m);
      is_branch = (m == AM_REL_DIR) || (m == AM_REL_IND) || (m == AM_BIT_DIR_REL)
         || (m == AM_BIT_IND_REL);
   endfunction

endpackage

// [decode_if.sv]
`timescale 1ns/1ps
interface decode_if;
   import amode_pkg::*;
   logic [7:0] opcode;
   pre_t pre;
   amode_t mode;
   logic [1:0] nbytes;
   logic use_y;
   logic ptr_word;
   logic short_only;
   logic halt;
   logic wait_for_interrupt_instr;
   logic illegal;
   modport decoder (input opcode, pre, output mode, nbytes, use_y, ptr_word, short_only, halt,
      wait_for_interrupt_instr, illegal);
   modport core (output opcode, pre, input mode, nbytes, use_y, ptr_word, short_only, halt,
      wait_for_interrupt_instr, illegal);
endinterface

// [amode_decoder.sv]
`timescale 1ns/1ps
module amode_decoder
   import amode_pkg::*;
(
   decode_if.decoder dif
);

   logic [3:0] hn;
   logic [3:0] ln;
   assign hn = dif.opcode[7:4];
   assign ln = dif.opcode[3:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Opcode row and prebyte to mode; an unauthorised prebyte is simply ignored
   always_comb begin
      dif.mode = AM_INHERENT;
      dif.nbytes = 2'd0; // Inherent has no trailing bytes
      dif.use_y = 1'b0;
      dif.ptr_word = 1'b0;
      dif.short_only = 1'b0;
      dif.halt = 1'b0;
      dif.wait_for_interrupt_instr = 1'b0;
      dif.illegal = 1'b0;
      case (hn)
         NIB_BIT_REL: begin
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_BIT_IND_REL : AM_BIT_DIR_REL;
            dif.nbytes = 2'd2;
            dif.short_only = 1'b1;
         end
         NIB_BIT: begin
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_BIT_IND : AM_BIT_DIR;
            dif.nbytes = 2'd1;
            dif.short_only = 1'b1;
         end
         NIB_JR: begin
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_REL_IND : AM_REL_DIR;
            dif.nbytes = 2'd1;
         end
         NIB_RMW_DIR: begin
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_IND_SHORT : AM_DIR_SHORT;
            dif.nbytes = 2'd1;
            dif.short_only = 1'b1;
         end
         NIB_INH_A: begin
            dif.mode = AM_INHERENT;
         end
         NIB_INH_X, NIB_INH_8, NIB_INH_9: begin
            dif.use_y = (dif.pre == PRE_SEL_Y);
            dif.illegal = ((hn == NIB_INH_8) && ILL_ROW8[ln])
               || ((hn == NIB_INH_9) && ILL_ROW9[ln]);
            dif.halt = (dif.opcode == OPC_HALT);
            dif.wait_for_interrupt_instr = (dif.opcode == OPC_WFI);
         end
         NIB_RMW_IDX, NIB_IDX_S: begin
            // Short indexed, plain or through a byte pointer
            dif.nbytes = 2'd1;
            dif.short_only = (hn == NIB_RMW_IDX);
            dif.mode = dif.pre[1] ? AM_IND_IDX_SHORT : AM_IDX_SHORT;
            dif.use_y = (dif.pre == PRE_SEL_Y) || (dif.pre == PRE_SEL_IND_Y);
         end
         NIB_RMW_IDX0, NIB_IDX_0: begin
            dif.mode = AM_IDX_NONE;
            dif.short_only = (hn == NIB_RMW_IDX0);
            dif.use_y = (dif.pre == PRE_SEL_Y);
         end
         NIB_IMM: begin
            dif.mode = AM_IMMEDIATE;
            dif.nbytes = 2'd1; // Literal follows the opcode
            dif.use_y = (dif.pre == PRE_SEL_Y);
         end
         NIB_DIR_S: begin
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_IND_SHORT : AM_DIR_SHORT;
            dif.nbytes = 2'd1;
         end
         NIB_DIR_L: begin
            // Long indirect still has a page-zero pointer address of one byte
            dif.mode = (dif.pre == PRE_SEL_IND) ? AM_IND_LONG : AM_DIR_LONG;
            dif.ptr_word = (dif.pre == PRE_SEL_IND);
            dif.nbytes = (dif.pre == PRE_SEL_IND) ? 2'd1 : 2'd2;
         end
         NIB_IDX_L: begin
            dif.mode = dif.pre[1] ? AM_IND_IDX_LONG : AM_IDX_LONG;
            dif.ptr_word = dif.pre[1];
            dif.nbytes = dif.pre[1] ? 2'd1 : 2'd2;
            dif.use_y = (dif.pre == PRE_SEL_Y) || (dif.pre == PRE_SEL_IND_Y);
         end
         default: begin
            dif.illegal = 1'b1;
         end
      endcase
   end

endmodule

// [cpu_addressing_mode_decode.sv]
`timescale 1ns/1ps
module cpu_addressing_mode_decode
   import amode_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic fetch_valid_in,
   input wire logic [7:0] fetch_byte_in,
   input wire logic [7:0] x_in,
   input wire logic [7:0] y_in,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic mem_rvalid_in,
   output logic fetch_ready_out,
   output logic mem_req_out,
   output logic [15:0] mem_addr_out,
   output logic done_out,
   output amode_t mode_out,
   output family_t family_out,
   output logic [2:0] length_out,
   output logic [15:0] ea_out,
   output logic [7:0] operand_out,
   output logic [15:0] target_out,
   output logic use_y_out,
   output logic short_only_out,
   output logic halt_req_out,
   output logic wfi_req_out,
   output logic illegal_reset_out
);

   decode_if dif ();

   amode_decoder u_dec (
      .dif(dif)
   );

   state_t state_reg, state_next;
   pre_t pre_reg, pre_next;
   logic [7:0] op_reg, op_next;
   logic [7:0] b1_reg, b1_next;
   logic [7:0] b2_reg, b2_next;
   logic [1:0] got_reg, got_next;
   logic [2:0] len_reg, len_next;
   logic [7:0] ptr_hi_reg, ptr_hi_next;
   logic [7:0] ptr_lo_reg, ptr_lo_next;
   logic sent_reg, sent_next;
   logic ready_reg, ready_next;
   logic req_reg, req_next;
   logic [15:0] maddr_reg, maddr_next;
   logic done_reg, done_next;
   amode_t mode_reg, mode_next;
   family_t fam_reg, fam_next;
   logic [2:0] olen_reg, olen_next;
   logic [15:0] ea_reg, ea_next;
   logic [7:0] opnd_reg, opnd_next;
   logic [15:0] tgt_reg, tgt_next;
   logic usey_reg, usey_next;
   logic sonly_reg, sonly_next;
   logic halt_reg, halt_next;
   logic wfi_reg, wfi_next;
   logic ill_reg, ill_next;
   logic take;
   logic [7:0] idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Address arithmetic
   function automatic logic [15:0] ea_calc(input amode_t m, input logic [7:0] ix,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] ph, input logic [7:0] pl);
      case (m)
         AM_DIR_SHORT, AM_BIT_DIR, AM_BIT_DIR_REL: ea_calc = {PAGE0_HI, a};
         AM_DIR_LONG: ea_calc = {a, b}; // Full 64 Kbyte reach
         AM_IDX_NONE: ea_calc = {PAGE0_HI, ix};
         AM_IDX_SHORT: ea_calc = {PAGE0_HI, ix} + {PAGE0_HI, a}; // Up to 1fe
         AM_IDX_LONG: ea_calc = {a, b} + {PAGE0_HI, ix};
         AM_IND_SHORT, AM_BIT_IND, AM_BIT_IND_REL: ea_calc = {PAGE0_HI, pl};
         AM_IND_LONG: ea_calc = {ph, pl};
         AM_IND_IDX_SHORT: ea_calc = {PAGE0_HI, pl} + {PAGE0_HI, ix};
         AM_IND_IDX_LONG: ea_calc = {ph, pl} + {PAGE0_HI, ix};
         default: ea_calc = 16'h0000;
      endcase
   endfunction

   // Sign extended byte offset; pc already points past the branch instruction
   function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
      rel_target = pc + {{8{off[7]}}, off};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Decoder sees the live byte while an opcode is awaited, the held one after
   assign dif.opcode = (state_reg == ST_OPCODE) ? fetch_byte_in : op_reg;
   assign dif.pre = pre_reg;
   assign take = fetch_valid_in && ready_reg;
   assign idx = dif.use_y ? y_in : x_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: prebyte, opcode, operand bytes, pointer reads, result
   always_comb begin
      state_next = state_reg;
      pre_next = pre_reg;
      op_next = op_reg;
      b1_next = b1_reg;
      b2_next = b2_reg;
      got_next = got_reg;
      len_next = len_reg;
      ptr_hi_next = ptr_hi_reg;
      ptr_lo_next = ptr_lo_reg;
      sent_next = sent_reg;
      maddr_next = maddr_reg;
      mode_next = mode_reg;
      fam_next = fam_reg;
      olen_next = olen_reg;
      ea_next = ea_reg;
      opnd_next = opnd_reg;
      tgt_next = tgt_reg;
      usey_next = usey_reg;
      sonly_next = sonly_reg;
      req_next = 1'b0;
      done_next = 1'b0;
      halt_next = 1'b0;
      wfi_next = 1'b0;
      ill_next = 1'b0;
      case (state_reg)
         ST_OPCODE: begin
            if (take) begin
               len_next = len_reg + 3'd1;
               if (pre_code(fetch_byte_in) != PRE_NONE && pre_reg == PRE_NONE) begin
                  pre_next = pre_code(fetch_byte_in);
               end else if (pre_code(fetch_byte_in) != PRE_NONE || dif.illegal) begin
                  // A second prebyte or an undefined code sits where an opcode must be
                  ill_next = 1'b1;
                  pre_next = PRE_NONE;
                  len_next = 3'd0;
               end else begin
                  op_next = fetch_byte_in;
                  got_next = 2'd0;
                  state_next = (dif.nbytes == 2'd0) ? ST_FINISH : ST_OPERAND;
               end
            end
         end
         ST_OPERAND: begin
            if (take) begin
               len_next = len_reg + 3'd1;
               got_next = got_reg + 2'd1;
               if (got_reg == 2'd0) begin
                  b1_next = fetch_byte_in;
               end else begin
                  b2_next = fetch_byte_in;
               end
               if (got_reg + 2'd1 == dif.nbytes) begin
                  state_next = is_indirect(dif.mode) ? ST_PTR_HI : ST_FINISH;
               end
            end
         end
         ST_PTR_HI, ST_PTR_LO: begin
            // Word pointers are high byte first; the low byte wraps inside page zero
            if (!sent_reg) begin
               req_next = 1'b1;
               sent_next = 1'b1;
               maddr_next = (state_reg == ST_PTR_HI) ? {PAGE0_HI, b1_reg}
                  : {PAGE0_HI, b1_reg + PTR_STEP};
            end else if (mem_rvalid_in) begin
               sent_next = 1'b0;
               if (state_reg == ST_PTR_HI && dif.ptr_word) begin
                  ptr_hi_next = mem_rdata_in;
                  state_next = ST_PTR_LO;
               end else begin
                  if (state_reg == ST_PTR_HI) begin
                     ptr_hi_next = 8'h00;
                  end
                  ptr_lo_next = mem_rdata_in;
                  state_next = ST_FINISH;
               end
            end
         end
         ST_FINISH: begin
            done_next = 1'b1;
            mode_next = dif.mode;
            fam_next = family_of(dif.mode);
            olen_next = len_reg;
            ea_next = ea_calc(dif.mode, idx, b1_reg, b2_reg, ptr_hi_reg, ptr_lo_reg);
            opnd_next = b1_reg; // Literal of an immediate
            case (dif.mode)
               AM_REL_DIR: tgt_next = rel_target(pc_in, b1_reg);
               AM_REL_IND: tgt_next = rel_target(pc_in, ptr_lo_reg);
               AM_BIT_DIR_REL, AM_BIT_IND_REL: tgt_next = rel_target(pc_in, b2_reg);
               default: tgt_next = pc_in;
            endcase
            usey_next = dif.use_y;
            sonly_next = dif.short_only;
            halt_next = dif.halt; // Stop oscillator request
            wfi_next = dif.wait_for_interrupt_instr; // Suspend until interrupt
            pre_next = PRE_NONE;
            len_next = 3'd0;
            state_next = ST_OPCODE;
         end
         default: begin
            state_next = ST_OPCODE;
         end
      endcase
      ready_next = (state_next == ST_OPCODE) || (state_next == ST_OPERAND);
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_reg <= ST_OPCODE;
         pre_reg <= PRE_NONE;
         op_reg <= 8'h00;
         b1_reg <= 8'h00;
         b2_reg <= 8'h00;
         got_reg <= 2'd0;
         len_reg <= 3'd0;
         ptr_hi_reg <= 8'h00;
         ptr_lo_reg <= 8'h00;
         sent_reg <= 1'b0;
         ready_reg <= 1'b0;
         req_reg <= 1'b0;
         maddr_reg <= 16'h0000;
         done_reg <= 1'b0;
         mode_reg <= AM_INHERENT;
         fam_reg <= FAM_INHERENT;
         olen_reg <= 3'd0;
         ea_reg <= 16'h0000;
         opnd_reg <= 8'h00;
         tgt_reg <= 16'h0000;
         usey_reg <= 1'b0;
         sonly_reg <= 1'b0;
         halt_reg <= 1'b0;
         wfi_reg <= 1'b0;
         ill_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pre_reg <= pre_next;
         op_reg <= op_next;
         b1_reg <= b1_next;
         b2_reg <= b2_next;
         got_reg <= got_next;
         len_reg <= len_next;
         ptr_hi_reg <= ptr_hi_next;
         ptr_lo_reg <= ptr_lo_next;
         sent_reg <= sent_next;
         ready_reg <= ready_next;
         req_reg <= req_next;
         maddr_reg <= maddr_next;
         done_reg <= done_next;
         mode_reg <= mode_next;
         fam_reg <= fam_next;
         olen_reg <= olen_next;
         ea_reg <= ea_next;
         opnd_reg <= opnd_next;
         tgt_reg <= tgt_next;
         usey_reg <= usey_next;
         sonly_reg <= sonly_next;
         halt_reg <= halt_next;
         wfi_reg <= wfi_next;
         ill_reg <= ill_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign fetch_ready_out = ready_reg;
   assign mem_req_out = req_reg;
   assign mem_addr_out = maddr_reg;
   assign done_out = done_reg;
   assign mode_out = mode_reg;
   assign family_out = fam_reg;
   assign length_out = olen_reg;
   assign ea_out = ea_reg;
   assign operand_out = opnd_reg;
   assign target_out = tgt_reg;
   assign use_y_out = usey_reg;
   assign short_only_out = sonly_reg;
   assign halt_req_out = halt_reg;
   assign wfi_req_out = wfi_reg;
   assign illegal_reset_out = ill_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks; pc is kept only so the branch reach can be measured
   logic [15:0] pc_seen_reg;
   logic [15:0] rel_diff;
   always_ff @(posedge sys_clk_in) begin
      pc_seen_reg <= (state_reg == ST_FINISH) ? pc_in : pc_seen_reg;
   end
   assign rel_diff = tgt_reg - pc_seen_reg;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_bad_code;
      state_reg == ST_OPCODE && take && pre_reg == PRE_NONE && dif.illegal
         && pre_code(fetch_byte_in) == PRE_NONE;
   endsequence
   sequence s_reset_pulse;
      illegal_reset_out ##1 !illegal_reset_out;
   endsequence
   sequence s_word_hi;
      state_reg == ST_PTR_HI && mem_req_out && dif.ptr_word;
   endsequence

   a_illegal_reset: assert property (s_bad_code |=> s_reset_pulse)
      else $error("undefined code byte did not raise reset");
   a_halt_inherent: assert property (halt_req_out |-> mode_out == AM_INHERENT
      && done_out)
      else $error("halt request outside an inherent result");
   a_wfi_pulse: assert property (wfi_req_out |-> done_out && mode_out == AM_INHERENT
      ##1 !wfi_req_out)
      else $error("wait request not a single inherent pulse");
   a_imm_length: assert property (done_out && mode_out == AM_IMMEDIATE
      |-> length_out == (use_y_out ? 3'd3 : 3'd2))
      else $error("immediate length wrong");
   a_short_page: assert property (done_out && (mode_out == AM_DIR_SHORT
      || mode_out == AM_IND_SHORT || mode_out == AM_BIT_DIR) |-> ea_out[15:8] == 8'h00)
      else $error("short form left page zero");
   a_idx_none_len: assert property (done_out && mode_out == AM_IDX_NONE
      |-> length_out == (use_y_out ? 3'd2 : 3'd1) && ea_out[15:8] == 8'h00)
      else $error("no-offset index length or range wrong");
   a_long_bytes: assert property (done_out && (mode_out == AM_DIR_LONG
      || mode_out == AM_IDX_LONG) |-> length_out == (use_y_out ? 3'd4 : 3'd3))
      else $error("long form length wrong");
   a_branch_reach: assert property (done_out && is_branch(mode_out)
      |-> $signed(rel_diff) >= -16'sd128 && $signed(rel_diff) <= 16'sd127)
      else $error("branch target out of reach");
   a_rmw_short: assert property (done_out && short_only_out |-> mode_out != AM_DIR_LONG
      && mode_out != AM_IDX_LONG && mode_out != AM_IND_LONG
      && mode_out != AM_IND_IDX_LONG)
      else $error("memory read-modify-write given a long mode");
   a_ptr_order: assert property (s_word_hi |-> ##[1:600] (mem_req_out
      && state_reg == ST_PTR_LO && mem_addr_out == {8'h00, b1_reg + 8'h01}))
      else $error("word pointer low byte not read after high byte");

endmodule

// [cpu_addressing_mode_decode_tb_top.sv]
`timescale 1ns/1ps
module cpu_addressing_mode_decode_tb_top;
   import amode_pkg::*;
   logic sys_clk_in, rst_in, fetch_valid_in, mem_rvalid_in;
   logic [7:0] fetch_byte_in, x_in, y_in, mem_rdata_in, b1, b2;
   logic [15:0] pc_in, mem_addr_out, ea_out, target_out;
   logic fetch_ready_out, mem_req_out, done_out, use_y_out, short_only_out;
   logic halt_req_out, wfi_req_out, illegal_reset_out;
   amode_t mode_out;
   family_t family_out;
   logic [2:0] length_out;
   logic [7:0] operand_out;
   logic [7:0] offs[$] = '{8'h80, 8'h7f, 8'h00};
   logic [31:0] rs = 32'h0000a0ad;
   logic [7:0] pg[256];
   logic [15:0] rd_q[$];
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;

   cpu_addressing_mode_decode dut_u (.sys_clk_in, .rst_in, .fetch_valid_in, .fetch_byte_in,
      .x_in, .y_in, .pc_in, .mem_rdata_in, .mem_rvalid_in, .fetch_ready_out, .mem_req_out,
      .mem_addr_out, .done_out, .mode_out, .family_out, .length_out, .ea_out, .operand_out,
      .target_out, .use_y_out, .short_only_out, .halt_req_out, .wfi_req_out,
      .illegal_reset_out);

   ////////////////////////////////////////////////////////////
   // Free-running clock and a hang guard sized well above the run
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   // Page-zero memory answers each read in the cycle it is raised and logs the address
   always @(negedge sys_clk_in) begin
      mem_rvalid_in = mem_req_out;
      mem_rdata_in = pg[mem_addr_out[7:0]];
      if (mem_req_out === 1'b1) rd_q.push_back(mem_addr_out);
   end
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////
   // Stimulus helpers; all driving happens at the falling edge
   function automatic logic [7:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[7:0];
   endfunction
   task automatic chk_addr(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_code(string nm, logic [7:0] e, logic [7:0] g);
      chk_addr(nm, {8'h00, e}, {8'h00, g});
   endtask
   // Waits for ready before offering a byte, so nothing is dropped
   task automatic put(logic [7:0] b);
      int k = 0;
      while (fetch_ready_out !== 1'b1 && k < 20) begin
         @(negedge sys_clk_in);
         k++;
      end
      fetch_valid_in = 1'b1;
      fetch_byte_in = b;
      @(negedge sys_clk_in);
   endtask
   task automatic run(string nm, logic [7:0] q[$], amode_t m, logic [15:0] ea);
      int k = 0;
      foreach (q[i]) put(q[i]);
      fetch_valid_in = 1'b0;
      while (done_out !== 1'b1 && k < 20) begin
         @(negedge sys_clk_in);
         k++;
      end
      chk_code("done", 8'h01, {7'h00, done_out});
      chk_code("mode", {3'h0, m}, {3'h0, mode_out});
      chk_code("length", 8'(q.size()), {5'h00, length_out});
      chk_addr("ea", ea, ea_out);
      $display("test %s finished", nm);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence; operands and index values are random, apart from three fixed branch offsets
   initial begin
      {rst_in, fetch_valid_in} = 2'b10;
      {fetch_byte_in, x_in, y_in, pc_in} = 40'h0;
      foreach (pg[i]) pg[i] = rnd();
      repeat (2) @(negedge sys_clk_in);
      rst_in = 1'b0;
      b1 = rnd();
      b2 = rnd();
      x_in = rnd();
      y_in = rnd();
      pc_in = {rnd(), rnd()};
      run("dir_long", '{8'hc6, b1, b2}, AM_DIR_LONG, {b1, b2});
      run("dir_short", '{8'hb6, b1}, AM_DIR_SHORT, {8'h00, b1});
      run("immediate", '{8'ha6, b2}, AM_IMMEDIATE, 16'h0000);
      chk_code("operand", b2, operand_out);
      run("inherent", '{8'h4c}, AM_INHERENT, 16'h0000);
      run("idx0_x", '{8'hf6}, AM_IDX_NONE, {8'h00, x_in});
      chk_code("use_y", 8'h00, {7'h00, use_y_out});
      run("idx0_y", '{8'h90, 8'hf6}, AM_IDX_NONE, {8'h00, y_in});
      chk_code("use_y", 8'h01, {7'h00, use_y_out});
      run("idx_short", '{8'he6, b1}, AM_IDX_SHORT, 16'(x_in) + 16'(b1));
      run("idx_long_y", '{8'h90, 8'hd6, b1, b2}, AM_IDX_LONG, 16'(y_in) + {b1, b2});
      run("rmw", '{8'h3c, b1}, AM_DIR_SHORT, {8'h00, b1});
      chk_code("short_only", 8'h01, {7'h00, short_only_out});
      offs.push_back(rnd());
      foreach (offs[i]) begin
         run("branch", '{8'h27, offs[i]}, AM_REL_DIR, 16'h0000);
         chk_addr("target", pc_in + {{8{offs[i][7]}}, offs[i]}, target_out);
      end
      run("wfi", '{8'h8f}, AM_INHERENT, 16'h0000);
      chk_code("wfi", 8'h01, {7'h00, wfi_req_out});
      chk_code("halt", 8'h00, {7'h00, halt_req_out});
      run("halt", '{8'h8e}, AM_INHERENT, 16'h0000);
      chk_code("halt", 8'h01, {7'h00, halt_req_out});
      rd_q.delete();
      run("ind_long", '{8'h92, 8'hc6, b1}, AM_IND_LONG, {pg[b1], pg[8'(b1 + 8'h01)]});
      chk_code("family", {5'h00, FAM_INDIRECT}, {5'h00, family_out});
      chk_addr("ptr_hi_addr", {8'h00, b1}, rd_q[0]);
      chk_addr("ptr_lo_addr", {8'h00, 8'(b1 + 8'h01)}, rd_q[1]);
      run("ind_idx_y", '{8'h91, 8'he6, b1}, AM_IND_IDX_SHORT, 16'(pg[b1]) + 16'(y_in));
      put(8'h93);
      fetch_valid_in = 1'b0;
      chk_code("illegal", 8'h01, {7'h00, illegal_reset_out});
      rst_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      rst_in = 1'b0;
      put(8'h90);
      put(8'h90);
      fetch_valid_in = 1'b0;
      chk_code("illegal", 8'h01, {7'h00, illegal_reset_out});
      $display("test illegal finished");
      report_and_stop();
   end
endmodule
